// ==== verilog/mfa_pkg.sv ====
package mfa_pkg;

    // Clock and refresh timing
    localparam longint unsigned CLK_HZ = 100_000_000;
    localparam longint unsigned REFRESH_PERIOD_MS = 1000;
    localparam longint unsigned REFRESH_CYCLES = CLK_HZ * REFRESH_PERIOD_MS / 1000;

    // Conventional holding register numbering
    localparam logic [16:0] REG_NUM_BASE = 17'h09c41; // 40001

    // Address regions: low and high protocol address of each
    localparam int NUM_REGIONS = 11;
    localparam logic [15:0] REGION_LO [NUM_REGIONS] = '{
        16'h0000, 16'h0400, 16'h1000, 16'h2c00, 16'h3c00, 16'h4400,
        16'h4c00, 16'h5400, 16'h5c00, 16'h6400, 16'h7000};
    localparam logic [15:0] REGION_HI [NUM_REGIONS] = '{
        16'h03ff, 16'h0c0b, 16'h1409, 16'h3007, 16'h401d, 16'h49c5,
        16'h51eb, 16'h5805, 16'h6007, 16'h6809, 16'h7007};

    // Writable pairs inside the used process data region
    localparam logic [15:0] LINE_TEMP_ADDR = 16'h6400;
    localparam logic [15:0] LINE_PRESS_ADDR = 16'h6402;

    // Exception codes
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
    localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;

    // Reset values
    localparam logic [31:0] LINE_VALUE_RESET = 32'h0000_0000;

    // Block request from the frame layer
    typedef struct packed {
        logic write;
        logic [15:0] start;
        logic [7:0] count;
    } mfa_req_t;

    // Reply word towards the frame layer
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } mfa_word_t;

    // End of reply
    typedef struct packed {
        logic done;
        logic [7:0] exc;
    } mfa_end_t;

endpackage

// ==== verilog/mfa_region_dec.sv ====
`timescale 1ns/1ns
module mfa_region_dec (
    // Address under test
    input wire logic [15:0] addr,
    // Decode result
    output logic hit,
    output logic [3:0] region,
    output logic writable
);
    import mfa_pkg::*;

    logic [NUM_REGIONS-1:0] in_region;

    // One comparator pair per region
    genvar g;
    generate
        for (g = 0; g < NUM_REGIONS; g++) begin : g_reg
            assign in_region[g] = (addr >= REGION_LO[g]) && (addr <= REGION_HI[g]);
        end
    endgenerate

    // Priority encode, regions never overlap
    always_comb begin
        region = 4'h0;
        for (int i = NUM_REGIONS - 1; i >= 0; i--) begin
            if (in_region[i]) begin
                region = 4'(i);
            end
        end
    end

    assign hit = |in_region;
    // Only the temperature and pressure pairs take writes
    assign writable = (addr[15:1] == LINE_TEMP_ADDR[15:1]) || (addr[15:1] == LINE_PRESS_ADDR[15:1]);

endmodule // mfa_region_dec

// ==== verilog/mfa_access.sv ====
// Function
// - Every value is a 32-bit pair of 16-bit registers, low register at even address in standard word order.
// - Floats and signed integers pass as raw 32-bit words, never converted.
// - Only answers requests from the master; never starts a transaction.
// - Protocol addresses are holding registers of the extended numbering space.
// - Serial port is 2-wire half-duplex; a setting picks ASCII or RTU framing.
// - Data refresh at most once per second; reads between see unchanged values.
// - Configurable word order: standard puts low word first, alternate high word first.
// - Block starting at an odd address has start and end lowered by one.
// - Register number equals protocol address plus 40001.
// - Values are served in fixed metric units, unaffected by display units.
// - Only line temperature and line pressure accept writes; all else read-only.
// - Addresses decode into fixed regions; others are outside the map.
`timescale 1ns/1ns
module mfa_access #(
    parameter longint unsigned REFRESH_COUNT = mfa_pkg::REFRESH_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Configuration
    input wire logic word_swap,
    input wire logic ascii_mode,
    // Request from frame layer
    input wire logic req_valid,
    input wire mfa_pkg::mfa_req_t req,
    // Write data words
    input wire logic wr_valid,
    input wire logic [15:0] wr_data,
    output logic wr_ready,
    // Reply to frame layer
    output mfa_pkg::mfa_word_t rsp_word,
    output mfa_pkg::mfa_end_t rsp_end,
    output logic [16:0] reg_number,
    // Serial port control
    output logic tx_enable,
    output logic framing_ascii,
    // Measurement core value port
    output logic refresh,
    output logic val_req,
    output logic [14:0] val_pair,
    input wire logic [31:0] val_rdata,
    // Line conditions written by the master
    output logic [31:0] line_temp,
    output logic [31:0] line_press
);
    import mfa_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_CHECK = 3'b001,
        S_FETCH = 3'b010,
        S_CAPT = 3'b011,
        S_WORD0 = 3'b100,
        S_WORD1 = 3'b101,
        S_WRITE = 3'b110,
        S_DONE = 3'b111
    } mfa_state_t;

    mfa_state_t state_r, state_nxt;
    logic write_r;
    logic [15:0] cur_r, start_r, end_r;
    logic [7:0] remain_r, count_r;
    logic [31:0] snap_r, line_temp_r, line_press_r;
    logic [15:0] wlo_r;
    logic [7:0] exc_r;
    logic [26:0] tick_r;
    logic pending_r;
    logic refresh_r, val_req_r, tx_enable_r, wr_ready_r, framing_ascii_r;
    logic [14:0] val_pair_r;
    mfa_word_t rsp_word_r;
    mfa_end_t rsp_end_r;
    logic [16:0] reg_number_r;

    // Request address correction
    wire [15:0] req_start_fix = req.start - {15'h0000, req.start[0]};
    wire [16:0] req_end_wide = {1'b0, req_start_fix} + {9'h000, req.count} - 17'h00001;
    wire [15:0] req_end_fix = req_end_wide[15:0];

    // Region check of both block ends
    wire start_hit, end_hit, start_wr, end_wr;
    wire [3:0] start_reg, end_reg;

    mfa_region_dec u_dec_start (
        .addr(start_r),
        .hit(start_hit),
        .region(start_reg),
        .writable(start_wr)
    );

    mfa_region_dec u_dec_end (
        .addr(end_r),
        .hit(end_hit),
        .region(end_reg),
        .writable(end_wr)
    );

    // A block must stay inside one region; writes only into writable pairs
    wire range_wrap = (count_r == 8'h00) || (end_r < start_r);
    wire read_ok = start_hit && end_hit && (start_reg == end_reg);
    wire write_ok = start_wr && end_wr;
    wire check_ok = !range_wrap && (write_r ? write_ok : read_ok);
    wire [7:0] check_exc = range_wrap ? EXC_ILLEGAL_VALUE : EXC_ILLEGAL_ADDR;

    // Word order: standard puts low half at the even address
    wire [15:0] even_word = word_swap ? snap_r[31:16] : snap_r[15:0];
    wire [15:0] odd_word = word_swap ? snap_r[15:0] : snap_r[31:16];
    wire [31:0] wr_pair = word_swap ? {wlo_r, wr_data} : {wr_data, wlo_r};
    wire wr_take = (state_r == S_WRITE) && wr_valid && wr_ready_r;
    wire last_word = (remain_r == 8'h01);
    // Driver covers the cycle before a word and every word or end marker launched
    wire reply_now = (state_r == S_WORD0) || (state_r == S_WORD1) || (state_r == S_DONE);
    wire reply_next = (state_nxt == S_WORD0) || (state_nxt == S_WORD1) || (state_nxt == S_DONE);

    // Refresh only when idle so that no reply straddles two refreshes
    wire tick_end = (tick_r == 27'(REFRESH_COUNT - 1));
    wire [26:0] tick_nxt = pending_r ? tick_r : (tick_end ? 27'h0000000 : tick_r + 27'h0000001);
    wire refresh_fire = pending_r && (state_r == S_IDLE) && !req_valid;

    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: begin
                if (req_valid && !refresh_r) begin
                    state_nxt = S_CHECK;
                end
            end
            S_CHECK: begin
                if (!check_ok) begin
                    state_nxt = S_DONE;
                end else if (write_r) begin
                    state_nxt = S_WRITE;
                end else begin
                    state_nxt = S_FETCH;
                end
            end
            S_FETCH: state_nxt = S_CAPT;
            S_CAPT: state_nxt = S_WORD0;
            S_WORD0: state_nxt = last_word ? S_DONE : S_WORD1;
            S_WORD1: state_nxt = last_word ? S_DONE : S_FETCH;
            S_WRITE: begin
                if (wr_take && last_word) begin
                    state_nxt = S_DONE;
                end
            end
            S_DONE: state_nxt = S_IDLE;
            default: state_nxt = S_IDLE;
        endcase
    end

    // State and request capture
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_r <= S_IDLE;
            write_r <= 1'b0;
            start_r <= 16'h0000;
            end_r <= 16'h0000;
            count_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            if (state_r == S_IDLE && req_valid && !refresh_r) begin
                write_r <= req.write;
                start_r <= req_start_fix;
                end_r <= req_end_fix;
                count_r <= req.count;
            end
        end
    end

    // Walk through the block one word at a time
    always_ff @(posedge clock) begin
        if (!rstn) begin
            cur_r <= 16'h0000;
            remain_r <= 8'h00;
        end else if (state_r == S_CHECK) begin
            cur_r <= start_r;
            remain_r <= count_r;
        end else if (state_r == S_WORD0 || state_r == S_WORD1 || wr_take) begin
            cur_r <= cur_r + 16'h0001;
            remain_r <= remain_r - 8'h01;
        end
    end

    // Fetch one whole 32-bit value per pair
    always_ff @(posedge clock) begin
        if (!rstn) begin
            val_req_r <= 1'b0;
            val_pair_r <= 15'h0000;
            snap_r <= 32'h0000_0000;
        end else begin
            val_req_r <= (state_nxt == S_FETCH);
            if (state_nxt == S_FETCH) begin
                val_pair_r <= (state_r == S_CHECK) ? start_r[15:1] : cur_r[15:1] + 15'h0001;
            end
            if (state_r == S_CAPT) begin
                snap_r <= val_rdata;
            end
        end
    end

    // Reply words and end marker
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rsp_word_r <= '0;
            rsp_end_r <= '0;
            exc_r <= EXC_NONE;
        end else begin
            rsp_word_r.valid <= (state_r == S_WORD0) || (state_r == S_WORD1);
            if (state_r == S_WORD0) begin
                rsp_word_r.data <= even_word;
            end else if (state_r == S_WORD1) begin
                rsp_word_r.data <= odd_word;
            end
            if (state_r == S_IDLE) begin
                exc_r <= EXC_NONE;
            end else if (state_r == S_CHECK && !check_ok) begin
                exc_r <= check_exc;
            end
            rsp_end_r.done <= (state_r == S_DONE);
            rsp_end_r.exc <= (state_r == S_DONE) ? exc_r : EXC_NONE;
        end
    end

    // Line temperature and pressure, committed a whole pair at once
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wlo_r <= 16'h0000;
            line_temp_r <= LINE_VALUE_RESET;
            line_press_r <= LINE_VALUE_RESET;
        end else if (wr_take) begin
            if (!cur_r[0]) begin
                wlo_r <= wr_data;
            end else if (cur_r[15:1] == LINE_TEMP_ADDR[15:1]) begin
                line_temp_r <= wr_pair;
            end else if (cur_r[15:1] == LINE_PRESS_ADDR[15:1]) begin
                line_press_r <= wr_pair;
            end
        end
    end

    // Half-duplex driver enable and link status
    always_ff @(posedge clock) begin
        if (!rstn) begin
            tx_enable_r <= 1'b0;
            wr_ready_r <= 1'b0;
            framing_ascii_r <= 1'b0;
            reg_number_r <= REG_NUM_BASE;
        end else begin
            // Driver on only while a reply is being formed
            tx_enable_r <= reply_now || reply_next;
            // Half a write pair would be lost, so ready ends with the last word
            wr_ready_r <= (state_nxt == S_WRITE) && !(wr_take && last_word);
            framing_ascii_r <= ascii_mode;
            if (state_r == S_CHECK) begin
                reg_number_r <= {1'b0, start_r} + REG_NUM_BASE;
            end
        end
    end

    // Refresh timer; the fire cycle opens the next period, so a deferred fire never shortens a gap
    always_ff @(posedge clock) begin
        if (!rstn) begin
            tick_r <= 27'h0000000;
            pending_r <= 1'b0;
            refresh_r <= 1'b0;
        end else begin
            tick_r <= refresh_fire ? 27'h0000001 : tick_nxt;
            if (tick_end) begin
                pending_r <= 1'b1; // set wins over the clear
            end else if (refresh_fire) begin
                pending_r <= 1'b0;
            end
            refresh_r <= refresh_fire;
        end
    end

    // Outputs straight from flops
    assign refresh = refresh_r;
    assign val_req = val_req_r;
    assign val_pair = val_pair_r;
    assign rsp_word = rsp_word_r;
    assign rsp_end = rsp_end_r;
    assign reg_number = reg_number_r;
    assign tx_enable = tx_enable_r;
    assign framing_ascii = framing_ascii_r;
    assign wr_ready = wr_ready_r;
    assign line_temp = line_temp_r;
    assign line_press = line_press_r;

endmodule // mfa_access

// ==== sim/mfa_access_checker.sv ====
`timescale 1ns/1ns
module mfa_access_checker #(
    parameter longint unsigned REFRESH_COUNT = 50
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Watched ports
    input wire logic ascii_mode,
    input wire logic wr_valid,
    input wire mfa_pkg::mfa_word_t rsp_word,
    input wire mfa_pkg::mfa_end_t rsp_end,
    input wire logic [16:0] reg_number,
    input wire logic tx_enable,
    input wire logic framing_ascii,
    input wire logic refresh,
    input wire logic val_req,
    input wire logic [31:0] line_temp,
    input wire logic [31:0] line_press
);
    import mfa_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    logic [31:0] gap_r;
    logic [16:0] rel_addr;
    // Served start relative to the register base
    assign rel_addr = reg_number - REG_NUM_BASE;
    // Cycles since last refresh; saturates so long idle runs stay legal
    always_ff @(posedge clock) begin
        if (!rstn || refresh) gap_r <= 32'h0;
        else if (gap_r != 32'hffffffff) gap_r <= gap_r + 32'h1;
    end
    property p_word_in_tx; rsp_word.valid |-> tx_enable; endproperty
    a_word_in_tx: assert property (p_word_in_tx) else $error("reply word without driver enable");
    property p_done_end; rsp_end.done |-> tx_enable ##1 (!tx_enable && !rsp_end.done); endproperty
    a_done_end: assert property (p_done_end) else $error("end pulse or enable release wrong");
    property p_fetch_word; val_req |-> ##3 rsp_word.valid; endproperty
    a_fetch_word: assert property (p_fetch_word) else $error("fetched pair not replied in time");
    property p_refresh_gap; refresh |-> gap_r >= 32'(REFRESH_COUNT - 1); endproperty
    a_refresh_gap: assert property (p_refresh_gap) else $error("refresh came too soon");
    property p_refresh_idle; refresh |-> !tx_enable && !val_req; endproperty
    a_refresh_idle: assert property (p_refresh_idle) else $error("refresh during a reply");
    property p_even_start; !rel_addr[0] && !rel_addr[16]; endproperty
    a_even_start: assert property (p_even_start) else $error("served start not even");
    property p_line_write; $past(rstn) && ($changed(line_temp) || $changed(line_press)) |-> $past(wr_valid);
    endproperty
    a_line_write: assert property (p_line_write) else $error("line value moved without write word");
    property p_framing; $past(rstn) |-> framing_ascii == $past(ascii_mode); endproperty
    a_framing: assert property (p_framing) else $error("framing select does not follow setting");
endmodule // mfa_access_checker
bind mfa_access mfa_access_checker #(.REFRESH_COUNT(REFRESH_COUNT)) u_chk (.clock(clock), .rstn(rstn),
    .ascii_mode(ascii_mode), .wr_valid(wr_valid), .rsp_word(rsp_word), .rsp_end(rsp_end),
    .reg_number(reg_number), .tx_enable(tx_enable), .framing_ascii(framing_ascii), .refresh(refresh),
    .val_req(val_req), .line_temp(line_temp), .line_press(line_press));

// ==== sim/mfa_core_model.sv ====
`timescale 1ns/1ns
module mfa_core_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Value port of the access block
    input wire logic refresh,
    input wire logic val_req,
    input wire logic [14:0] val_pair,
    output logic [31:0] val_rdata,
    // Snapshot number seen by the bench
    output logic [15:0] gen
);
    // Values move only on refresh; data is held one cycle, then scrambled
    always @(posedge clock) begin
        if (!rstn) gen <= 16'h0;
        else if (refresh) gen <= gen + 16'h1;
        if (!rstn) val_rdata <= 32'h5a5a_a5a5;
        else if (val_req) val_rdata <= {gen, 1'b0, val_pair};
        else val_rdata <= ~val_rdata;
    end
endmodule // mfa_core_model

// ==== sim/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    import mfa_pkg::*;
    localparam longint unsigned RC = 50;
    logic clock = 1'b0;
    logic rstn, word_swap, ascii_mode, req_valid, wr_valid, wr_ready, tx_enable, framing_ascii, refresh, val_req;
    mfa_req_t req;
    logic [15:0] wr_data, gen;
    mfa_word_t rsp_word;
    mfa_end_t rsp_end;
    logic [16:0] reg_number;
    logic [14:0] val_pair;
    logic [31:0] val_rdata, line_temp, line_press, v2, v3;
    logic [15:0] got [4];
    logic [7:0] got_exc;
    int failures = 0;
    int checks_done = 0;
    int tw;
    // Free-running system clock
    always #5 clock = ~clock;
    mfa_access #(.REFRESH_COUNT(RC)) u_dut (.clock(clock), .rstn(rstn), .word_swap(word_swap),
        .ascii_mode(ascii_mode), .req_valid(req_valid), .req(req), .wr_valid(wr_valid), .wr_data(wr_data),
        .wr_ready(wr_ready), .rsp_word(rsp_word), .rsp_end(rsp_end), .reg_number(reg_number),
        .tx_enable(tx_enable), .framing_ascii(framing_ascii), .refresh(refresh), .val_req(val_req),
        .val_pair(val_pair), .val_rdata(val_rdata), .line_temp(line_temp), .line_press(line_press));
    mfa_core_model u_core (.clock(clock), .rstn(rstn), .refresh(refresh), .val_req(val_req),
        .val_pair(val_pair), .val_rdata(val_rdata), .gen(gen));
    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One request; collects reply words and end code, feeds two write words
    task automatic run(input logic wr, input logic [15:0] st, input logic [7:0] n, input logic [31:0] wv);
        int nr, nw;
        nr = 0;
        nw = 0;
        tw = -1;
        got_exc = 8'hff;
        while (refresh) @(negedge clock); // Refused while refresh pulses
        req_valid = 1'b1;
        req = '{write: wr, start: st, count: n};
        @(negedge clock);
        req_valid = 1'b0;
        for (int t = 0; t < 40; t++) begin
            if (rsp_word.valid === 1'b1 && nr < 4) begin
                if (nr == 0) tw = t;
                got[nr] = rsp_word.data;
                nr++;
            end
            if (rsp_end.done === 1'b1) begin
                got_exc = rsp_end.exc;
                break;
            end
            wr_valid = wr && wr_ready === 1'b1 && nw < 2;
            wr_data = (nw == 0) ? wv[15:0] : wv[31:16];
            if (wr_valid) nw++;
            @(negedge clock);
        end
        wr_valid = 1'b0;
        @(negedge clock);
    endtask
    task automatic s_reset();
        chk("reg_number", 32'h0000_9c41, {15'h0, reg_number});
        chk("tx_enable", 32'h0, {31'h0, tx_enable});
        chk("line_temp", LINE_VALUE_RESET, line_temp);
    endtask
    task automatic s_read_std();
        word_swap = 1'b0;
        run(1'b0, 16'h0004, 8'h02, 32'h0);
        v2 = {gen, 1'b0, 15'h0002};
        chk("low word", {16'h0, v2[15:0]}, {16'h0, got[0]});
        chk("high word", {16'h0, v2[31:16]}, {16'h0, got[1]});
        chk("exc", 32'h0, {24'h0, got_exc});
        chk("reg_number", 32'h0000_9c45, {15'h0, reg_number});
        chk("latency", 32'h4, tw);
    endtask
    task automatic s_read_odd();
        word_swap = 1'b1;
        ascii_mode = 1'b1;
        run(1'b0, 16'h0005, 8'h04, 32'h0);
        v2 = {gen, 1'b0, 15'h0002};
        v3 = {gen, 1'b0, 15'h0003};
        chk("pair2 hi", {16'h0, v2[31:16]}, {16'h0, got[0]});
        chk("pair2 lo", {16'h0, v2[15:0]}, {16'h0, got[1]});
        chk("pair3 hi", {16'h0, v3[31:16]}, {16'h0, got[2]});
        chk("pair3 lo", {16'h0, v3[15:0]}, {16'h0, got[3]});
        chk("reg_number", 32'h0000_9c45, {15'h0, reg_number});
        chk("framing", 32'h1, {31'h0, framing_ascii});
        word_swap = 1'b0;
    endtask
    task automatic s_map();
        logic [15:0] adr [5] = '{16'h0000, 16'h0c0a, 16'h0c0c, 16'h7006, 16'h7008};
        logic [7:0] ex [5] = '{EXC_NONE, EXC_NONE, EXC_ILLEGAL_ADDR, EXC_NONE, EXC_ILLEGAL_ADDR};
        for (int i = 0; i < 5; i++) begin
            run(1'b0, adr[i], 8'h02, 32'h0);
            chk("region exc", {24'h0, ex[i]}, {24'h0, got_exc});
        end
    endtask
    task automatic s_write();
        run(1'b1, LINE_TEMP_ADDR, 8'h02, 32'h4049_0fdb);
        chk("line_temp", 32'h4049_0fdb, line_temp);
        run(1'b1, LINE_PRESS_ADDR, 8'h02, 32'h1234_abcd);
        chk("line_press", 32'h1234_abcd, line_press);
        run(1'b1, 16'h0004, 8'h02, 32'hdead_beef);
        chk("ro exc", {24'h0, EXC_ILLEGAL_ADDR}, {24'h0, got_exc});
        chk("line_temp kept", 32'h4049_0fdb, line_temp);
    endtask
    // Two polls inside one period agree; a poll one period later sees the next snapshot
    task automatic s_poll();
        logic [15:0] first_hi;
        while (refresh !== 1'b1) @(negedge clock);
        @(negedge clock);
        run(1'b0, 16'h1002, 8'h02, 32'h0);
        first_hi = got[1];
        run(1'b0, 16'h1002, 8'h02, 32'h0);
        chk("same snapshot", {16'h0, first_hi}, {16'h0, got[1]});
        repeat (RC) @(negedge clock);
        run(1'b0, 16'h1002, 8'h02, 32'h0);
        chk("next snapshot", {16'h0, first_hi + 16'h1}, {16'h0, got[1]});
    endtask
    task automatic s_refresh();
        int n;
        n = 0;
        while (refresh !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        n = 0;
        @(negedge clock);
        while (refresh !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        chk("refresh period", 32'(RC), n + 1);
    endtask
    // Bench cut-off well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        close_out();
    end
    // Main sequence, inputs move on falling edges
    initial begin
        rstn = 1'b0;
        word_swap = 1'b0;
        ascii_mode = 1'b0;
        req_valid = 1'b0;
        req = '0;
        wr_valid = 1'b0;
        wr_data = 16'h0;
        repeat (5) @(negedge clock);
        rstn = 1'b1;
        s_reset();
        s_read_std();
        s_read_odd();
        s_map();
        s_write();
        s_poll();
        s_refresh();
        close_out();
    end
endmodule // testbench
